/* pkg/swwe_defs.vh */
// constants for the standalone watchdog with enable
`ifndef SWWE_DEFS_VH
`define SWWE_DEFS_VH

// clock period and the status fall limit, both in ns
`define SWWE_CLK_PERIOD_NS   50
`define SWWE_STATUS_FALL_NS  200
// longest time, so round down; never below one cycle
`define SWWE_STATUS_FALL_CYC ((`SWWE_STATUS_FALL_NS / `SWWE_CLK_PERIOD_NS) \
                              > 0 ? (`SWWE_STATUS_FALL_NS /                \
                              `SWWE_CLK_PERIOD_NS) : 1)

// default lengths in clock cycles and the counter width (plain defaults, parameters override)
`define SWWE_TMO_PROG_CYC    32'd200000
`define SWWE_TMO_TIED_CYC    32'd400000
`define SWWE_TMO_OPEN_CYC    32'd40000
`define SWWE_TRST_CYC        32'd4000
`define SWWE_CNT_W           32

// encoding of the timing capacitor pin condition
`define SWWE_CAP_OPEN        2'h0
`define SWWE_CAP_TIED        2'h1
`define SWWE_CAP_PROG        2'h2
`define SWWE_CAP_RSVD        2'h3

// one-hot state codes
`define SWWE_ST_OFF          4'h1
`define SWWE_ST_ARM          4'h2
`define SWWE_ST_RUN          4'h4
`define SWWE_ST_RST          4'h8

// reset values of the flops
`define SWWE_RST_STATE       4'h2
`define SWWE_RST_STATUS_OE   1'b1
`define SWWE_RST_RESET_OE    1'b0
`define SWWE_RST_KICK_PREV   1'b1

`endif

/* rtl/swwe_counter.v */
// cycle counter with clear, run and an expiry flag at a limit
`timescale 1ns/1ns
module swwe_counter
#(
   parameter CNT_W = 32
)
(
   input  wire             clk,      // system clock
   input  wire             sys_rst,  // synchronous reset, high
   input  wire             clear,    // restart from zero
   input  wire             run,      // count this cycle
   input  wire [CNT_W-1:0] limit,    // cycles until expiry
   output wire             expired,  // last counted cycle reached
   output wire [CNT_W-1:0] count     // current count
);

   reg  [CNT_W-1:0] count_r;
   wire [CNT_W:0]   count_inc;

   // one extra bit so a limit at full scale cannot wrap the compare
   assign count_inc = {1'b0, count_r} + {{CNT_W{1'b0}}, 1'b1};
   // a limit of zero behaves as one cycle
   assign expired   = run & (count_inc >= {1'b0, limit});
   assign count     = count_r;

   // hold at expiry; the owner leaves the state and clears us
   always @(posedge clk)
   begin
      if (sys_rst || clear)
         count_r <= {CNT_W{1'b0}};
      else if (run && !expired)
         count_r <= count_inc[CNT_W-1:0];
   end

endmodule // swwe_counter

/* rtl/swwe_top.v */
// watchdog core: kick timing, reset pulse and enable status logic
//
// Contract
// [RL1] activate low pulls status low quickly
// [RL2] activate low ignores kicks, reset released
// [RL3] status releases reset delay after activate
// [RL4] undriven activate input reads as high
// [RL5] select pin low disables watchdog timeouts
// [RL6] falling kick edge restarts count; expiry times out
// [RL7] kicks ignored during reset or disable
// [RL8] timeout drives reset low for delay
// [RL9] select and capacitor pins choose timeout
// [RL10] host keeps kick at defined level
// [RL11] lengths in cycles; count restarts after reset
// [RL12] outputs open-drain: low drive or released
`timescale 1ns/1ns
`include "swwe_defs.vh"
module swwe_top
#(
   parameter CNT_W         = `SWWE_CNT_W,        // counter width
   parameter TMO_PROG_CYC  = `SWWE_TMO_PROG_CYC, // capacitor timeout
   parameter TMO_TIED_CYC  = `SWWE_TMO_TIED_CYC, // supply-tied timeout
   parameter TMO_OPEN_CYC  = `SWWE_TMO_OPEN_CYC, // open pin timeout
   parameter TRST_CYC      = `SWWE_TRST_CYC      // reset delay
)
(
   input  wire       clk,                  // 20 MHz system clock
   input  wire       sys_rst,              // synchronous reset, high
   input  wire       activate_in,          // enable level when driven
   input  wire       activate_in_driven,   // high while enable is driven
   input  wire       kick_in,              // kick from the host
   input  wire       timeout_select_pin,   // low disables watchdog
   input  wire [1:0] timing_cap_pin,       // open, tied, or capacitor
   output reg        timeout_reset_n_o,    // pin drive value, always 0
   output reg        timeout_reset_n_oe,   // high while pulling low
   output reg        activate_status_out_o,  // pin drive value, 0
   output reg        activate_status_out_oe  // high while pulling low
);

   localparam ST_OFF = `SWWE_ST_OFF; // activate low
   localparam ST_ARM = `SWWE_ST_ARM; // waiting delay before status
   localparam ST_RUN = `SWWE_ST_RUN; // watching kicks
   localparam ST_RST = `SWWE_ST_RST; // driving the reset pulse

   localparam [CNT_W-1:0] TMO_PROG = TMO_PROG_CYC[CNT_W-1:0];
   localparam [CNT_W-1:0] TMO_TIED = TMO_TIED_CYC[CNT_W-1:0];
   localparam [CNT_W-1:0] TMO_OPEN = TMO_OPEN_CYC[CNT_W-1:0];
   localparam [CNT_W-1:0] TRST     = TRST_CYC[CNT_W-1:0];

   reg  [3:0]       state_r;
   reg  [3:0]       state_nxt;
   reg              kick_prev_r;
   reg  [CNT_W-1:0] tmo_limit;

   wire             act_eff;
   wire             wd_disabled;
   wire             kick_fall;
   wire             kick_ok;
   wire             state_chg;
   wire             tmo_run;
   wire             tmo_clear;
   wire             tmo_expired;
   wire             dly_run;
   wire             dly_expired;

   // a floating enable is pulled up inside, so it counts as high
   assign act_eff = activate_in_driven ? activate_in : 1'b1; // [RL4]

   // select pin at ground turns the timer off entirely
   assign wd_disabled = ~timeout_select_pin; // [RL5]

   // the kick line must sit at a real level; a floating line would
   // give random edges, which are harmless only while disabled or outside the run state
   assign kick_fall = kick_prev_r & ~kick_in; // [RL10]

   // edges count only while running and enabled, never in the pulse
   assign kick_ok = kick_fall & (state_r == ST_RUN) & ~wd_disabled; // [RL7]

   // choose the timeout from the timing capacitor pin condition
   always @*
   begin
      case (timing_cap_pin) // [RL9]
         `SWWE_CAP_PROG: tmo_limit = TMO_PROG;
         `SWWE_CAP_TIED: tmo_limit = TMO_TIED;
         `SWWE_CAP_OPEN: tmo_limit = TMO_OPEN;
         default:        tmo_limit = TMO_OPEN;
      endcase
   end

   // each counter starts from zero on entry to a new state
   assign state_chg = (state_nxt != state_r);

   // timeout counter: runs only while watching, restarts on a kick
   assign tmo_run   = (state_r == ST_RUN) & ~wd_disabled;
   // leaving the pulse re-enters run with a fresh count of zero
   assign tmo_clear = kick_ok | ~tmo_run | state_chg; // [RL6] [RL11]

   swwe_counter
   #(
      .CNT_W (CNT_W)
   )
   u_tmo_cnt
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (tmo_clear),
      .run     (tmo_run),
      .limit   (tmo_limit),
      .expired (tmo_expired),
      .count   ()
   );

   // one delay counter serves both the arm wait and the reset pulse;
   // they never overlap, so sharing it saves a wide register
   assign dly_run = (state_r == ST_ARM) | (state_r == ST_RST);

   swwe_counter
   #(
      .CNT_W (CNT_W)
   )
   u_dly_cnt
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (state_chg),
      .run     (dly_run),
      .limit   (TRST),
      .expired (dly_expired),
      .count   ()
   );

   // next state; a low enable overrides everything else
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF:
         begin
            // kicks and timeouts have no effect while off
            if (act_eff)
               state_nxt = ST_ARM; // [RL2]
         end
         ST_ARM:
         begin
            if (!act_eff)
               state_nxt = ST_OFF; // [RL1]
            else if (dly_expired)
               state_nxt = ST_RUN; // [RL3]
         end
         ST_RUN:
         begin
            if (!act_eff)
               state_nxt = ST_OFF; // [RL1]
            else if (tmo_expired && !kick_ok)
               state_nxt = ST_RST; // [RL6]
         end
         ST_RST:
         begin
            // the pulse is cut short only by the enable going low
            if (!act_eff)
               state_nxt = ST_OFF; // [RL2]
            else if (dly_expired)
               state_nxt = ST_RUN; // [RL8]
         end
         default:
            state_nxt = ST_ARM;
      endcase
   end

   // state and kick history
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_r     <= `SWWE_RST_STATE;
         kick_prev_r <= `SWWE_RST_KICK_PREV;
      end
      else
      begin
         state_r     <= state_nxt;
         kick_prev_r <= kick_in;
      end
   end

   // outputs registered from the next state, so the status pulls low
   // one cycle after enable falls, well inside the fall limit
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         timeout_reset_n_oe     <= `SWWE_RST_RESET_OE;
         activate_status_out_oe <= `SWWE_RST_STATUS_OE;
      end
      else
      begin
         // status held low while off and during the arm wait
         activate_status_out_oe <= (state_nxt == ST_OFF) |
                                   (state_nxt == ST_ARM); // [RL1] [RL3]
         // reset pulled low for the delay length unless enable falls first
         timeout_reset_n_oe     <= (state_nxt == ST_RST); // [RL8] [RL2]
      end
   end

   // open drain: the drive value is always low, only the enable moves
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         timeout_reset_n_o     <= 1'b0;
         activate_status_out_o <= 1'b0;
      end
      else
      begin
         timeout_reset_n_o     <= 1'b0; // [RL12]
         activate_status_out_o <= 1'b0; // [RL12]
      end
   end

endmodule // swwe_top

/* test/swwe_host.sv */
// host model that kicks the watchdog
`timescale 1ns/1ns
module swwe_host
(
   input  wire       clk,     // clock
   input  wire       go,      // kick while high
   input  wire [7:0] period,  // high cycles between kicks
   output reg        kick_in  // kick line
);
   reg [7:0] cnt_r = 8'h00;
   initial kick_in = 1'b1;
   // one low cycle a period; held high when idle, never floating
   always @(posedge clk)
   begin
      cnt_r   <= (!go || cnt_r >= period) ? 8'h00 : cnt_r + 8'h01;
      kick_in <= !(go && cnt_r == period);
   end
endmodule // swwe_host

/* test/swwe_props.sv */
// assertion checker on the watchdog core ports
`timescale 1ns/1ns
module swwe_props
#(
   parameter TRST_CYC = 8
)
(
   input wire       clk,                    // clock
   input wire       sys_rst,                // reset
   input wire       activate_in,            // enable
   input wire       activate_in_driven,     // driven
   input wire       kick_in,                // kick
   input wire       timeout_select_pin,     // select
   input wire [1:0] timing_cap_pin,         // cap code
   input wire       timeout_reset_n_o,      // drive
   input wire       timeout_reset_n_oe,     // pull
   input wire       activate_status_out_o,  // drive
   input wire       activate_status_out_oe  // pull
);
   wire       en = !activate_in_driven || activate_in;
   wire       st = activate_status_out_oe;
   wire       rs = timeout_reset_n_oe;
   reg [15:0] st_cnt_r;
   reg [15:0] rs_cnt_r;
   reg        off_seen_r;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // run lengths; power-up release is excluded as it has no off phase
   always @(posedge clk)
   begin
      off_seen_r <= !sys_rst && (off_seen_r || !en);
      st_cnt_r   <= (en && st) ? st_cnt_r + 16'h1 : 16'h0;
      rs_cnt_r   <= rs ? rs_cnt_r + 16'h1 : 16'h0;
   end
   property p_off_st; !en |=> st; endproperty
   a_off_st: assert property (p_off_st) else $error("status");
   property p_off_rs; !en |=> !rs; endproperty
   a_off_rs: assert property (p_off_rs) else $error("reset on");
   property p_st_len; $fell(st) && off_seen_r |-> st_cnt_r == TRST_CYC + 1;
   endproperty
   a_st_len: assert property (p_st_len) else $error("hold");
   property p_st_why; $rose(st) |-> $past(activate_in_driven) &&
      !$past(activate_in); endproperty
   a_st_why: assert property (p_st_why) else $error("float");
   property p_sel; !timeout_select_pin |=> !$rose(rs); endproperty
   a_sel: assert property (p_sel) else $error("select");
   property p_rs_why; $rose(rs) |-> $past(en) && !$past(st) &&
      $past(timeout_select_pin); endproperty
   a_rs_why: assert property (p_rs_why) else $error("cause");
   property p_rs_len; $fell(rs) && $past(en) |-> rs_cnt_r == TRST_CYC;
   endproperty
   a_rs_len: assert property (p_rs_len) else $error("pulse");
   property p_gap; $fell(rs) |-> !rs [*8]; endproperty
   a_gap: assert property (p_gap) else $error("restart");
   property p_od; !timeout_reset_n_o && !activate_status_out_o; endproperty
   a_od: assert property (p_od) else $error("drive");
endmodule // swwe_props

/* test/test_swwe_top.sv */
// testbench for the watchdog core
`timescale 1ns/1ns
module test_swwe_top;
   localparam TRST = 12;
   reg        clk = 1'b0;
   reg        sys_rst = 1'b1;
   reg        en_lvl = 1'b1;
   reg        en_drv = 1'b0;
   reg        sel = 1'b1;
   reg  [1:0] cap = 2'h0;
   reg        go = 1'b0;
   wire       kick;
   wire       rs_o;
   wire       rs_oe;
   wire       st_o;
   wire       st_oe;
   integer    n_mismatch = 0;
   integer    checks_done = 0;
   reg [31:0] n;
   always #25 clk = ~clk;
   swwe_host host_u (.clk(clk), .go(go), .period(8'h05), .kick_in(kick));
   swwe_top #(.TMO_PROG_CYC(20), .TMO_TIED_CYC(30), .TMO_OPEN_CYC(12),
      .TRST_CYC(TRST)) dut_u (.clk(clk), .sys_rst(sys_rst),
      .activate_in(en_lvl), .activate_in_driven(en_drv), .kick_in(kick),
      .timeout_select_pin(sel), .timing_cap_pin(cap),
      .timeout_reset_n_o(rs_o), .timeout_reset_n_oe(rs_oe),
      .activate_status_out_o(st_o), .activate_status_out_oe(st_oe));
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0s expected %0d seen %0d", what, exp, seen);
         end
      end
   endtask
   // negedges until status (which=1) or reset pull reads val
   task wait_for(input which, input val);
      begin
         n = 0;
         while ((which ? st_oe : rs_oe) !== val)
         begin
            @(negedge clk);
            n = n + 1;
            if (n > 300)
            begin
               n_mismatch = n_mismatch + 1;
               final_report;
            end
         end
      end
   endtask
   // off phase, floating release, two timeouts, kicked pulse and run
   task t_timeout(input [1:0] c, input [31:0] lim);
      begin
         @(posedge clk);
         en_drv <= 1'b1;
         en_lvl <= 1'b0;
         cap    <= c;
         go     <= 1'b0;
         @(posedge clk);
         en_drv <= 1'b0;
         @(negedge clk);
         check(st_oe, 1'b1, "st_low");
         check(rs_oe, 1'b0, "rs_free");
         wait_for(1'b1, 1'b0);
         check(n, TRST + 1, "st_hold");
         wait_for(1'b0, 1'b1);
         check(n, lim, "timeout");
         wait_for(1'b0, 1'b0);
         check(n, TRST, "rs_len");
         // a second full timeout shows the count restarted from zero
         wait_for(1'b0, 1'b1);
         check(n, lim, "re_tmo");
         // kicks land inside this pulse and must not change its length
         @(posedge clk);
         go <= 1'b1;
         wait_for(1'b0, 1'b0);
         check(n, TRST, "rs_len2");
         n = 0;
         repeat (60)
         begin
            @(negedge clk);
            n = n + rs_oe;
         end
         check(n, 0, "kicked");
      end
   endtask
   // dis=0: select low, no kicks; dis=1: enable low with kicks
   task t_quiet(input dis);
      begin
         @(posedge clk);
         sel    <= dis;
         en_drv <= dis;
         en_lvl <= 1'b0;
         go     <= dis;
         @(posedge clk);
         n = 0;
         repeat (80)
         begin
            @(negedge clk);
            n = n + rs_oe + (st_oe !== dis);
         end
         check(n, 0, "quiet");
      end
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_timeout(2'h0, 12);
      t_timeout(2'h1, 30);
      t_timeout(2'h2, 20);
      t_timeout(2'h3, 12);
      t_quiet(1'b0);
      t_quiet(1'b1);
      final_report;
   end
endmodule // test_swwe_top
bind swwe_top swwe_props #(.TRST_CYC(TRST_CYC)) props_u (.clk(clk),
   .sys_rst(sys_rst), .activate_in(activate_in),
   .activate_in_driven(activate_in_driven), .kick_in(kick_in),
   .timeout_select_pin(timeout_select_pin),
   .timing_cap_pin(timing_cap_pin), .timeout_reset_n_o(timeout_reset_n_o),
   .timeout_reset_n_oe(timeout_reset_n_oe),
   .activate_status_out_o(activate_status_out_o),
   .activate_status_out_oe(activate_status_out_oe));
